// >>> core/psbs_link_if.sv
`timescale 1ns/1ps
// ==========================================================================
// carrier between the system side and the link-side sequencer
// ==========================================================================
interface psbs_link_if;
	import psbs_pkg::*;
	psbs_cfg_s cfg;       // configuration, already in the link domain
	logic      busy;      // burst in progress (link domain level)
	logic      cross_tgl; // toggles once per row crossing
	logic      start_tgl; // toggles once per burst start
	modport seq (input cfg, output busy, cross_tgl, start_tgl);
	modport ctl (output cfg, input busy, cross_tgl, start_tgl);
endinterface : psbs_link_if

// >>> core/psbs_pkg.sv
// ==========================================================================
// shared constants and types for the burst bus sequencer
// ==========================================================================
package psbs_pkg;
	localparam int            PSBS_LC_W    = 3;     // latency code width
	localparam int            PSBS_WORDS_W = 6;     // burst length field width
	localparam int            PSBS_CNT_W   = 8;     // status counter width
	localparam logic [2:0]    PSBS_LC_MIN  = 3'h1;  // a code of zero still stalls one cycle
	localparam logic [2:0]    PSBS_LC_RST  = 3'h2;  // latency code after reset
	localparam logic [5:0]    PSBS_WORDS_CONT = 6'h00; // zero words means continuous burst
	localparam logic [5:0]    PSBS_WORDS_RST  = 6'h04; // burst length after reset
	localparam logic          PSBS_POL_LOW = 1'b0;  // stall indicator active low
	localparam logic          PSBS_MODE_SYNC = 1'b0; // operating mode bit value for synchronous mode

	// ==========================================================================
	// sequencer states
	// ==========================================================================
	typedef enum logic [1:0] {
		PSBS_IDLE = 2'b00, // no burst, waiting for an address strobe
		PSBS_LAT  = 2'b01, // stalling: initial latency or row crossing
		PSBS_DATA = 2'b10, // one data word per clock
		PSBS_DONE = 2'b11  // defined length reached, select still low
	} psbs_state_e;

	// ==========================================================================
	// bus configuration as seen by the sequencer
	// ==========================================================================
	typedef struct packed {
		logic [PSBS_LC_W-1:0]    latency_code;       // stall length in clocks
		logic                    wait_timing_bit;    // 1: indicator one clock early
		logic                    operating_mode_bit; // 0: synchronous/burst allowed
		logic                    fixed_latency;      // 1: fixed latency mode
		logic                    wait_polarity;      // 0: active low
		logic                    wrap;               // 1: wrap inside the row
		logic [PSBS_WORDS_W-1:0] burst_words;        // 0: continuous
	} psbs_cfg_s;

	localparam psbs_cfg_s PSBS_CFG_RST = '{PSBS_LC_RST, 1'b0, PSBS_MODE_SYNC, 1'b0,
		PSBS_POL_LOW, 1'b0, PSBS_WORDS_RST};
endpackage : psbs_pkg

// >>> core/psbs_seq.sv
`timescale 1ns/1ps
// ==========================================================================
// link-side burst sequencer, clocked by the controller's bus clock
// ==========================================================================
module psbs_seq import psbs_pkg::*; #(
	parameter int COL_W = 7                 // words per row = 2**COL_W
) (
	input  wire logic             clk_link_i,    // bus clock from controller
	input  wire logic             rst_link_n,    // link reset, released synchronously
	input  wire logic             ce_n_i,        // chip select, active low
	input  wire logic             adv_n_i,       // address_valid_strobe, active low
	input  wire logic             we_n_i,        // write strobe, active low
	input  wire logic [COL_W-1:0] col_i,         // column part of the address
	psbs_link_if.seq              lnk,           // configuration and status
	output logic                  wait_o,        // stall indicator level
	output logic                  wait_oe_o,     // stall indicator driven
	output logic                  dq_oe_o,       // read data driven
	output logic                  word_strobe_o  // a data word moves this clock
);
	localparam logic [COL_W-1:0] ROW_LAST = '1; // last column of a row

	psbs_state_e             state, next_state;      // sequencer state
	logic [PSBS_LC_W-1:0]    cnt, next_cnt;          // remaining stall clocks
	logic [COL_W-1:0]        col, next_col;          // current column
	logic [PSBS_WORDS_W-1:0] left, next_left;        // words left, 0 when continuous
	logic                    is_wr, next_is_wr;      // burst is a write
	logic                    cross_t, next_cross_t;  // crossing toggle
	logic                    start_t, next_start_t;  // start toggle
	logic                    next_wait, next_wait_oe, next_dq_oe, next_strobe;
	logic [PSBS_LC_W-1:0]    lat_eff;                // latency with zero clamped
	logic                    start, stall_act, early;

	// ==========================================================================
	// next state
	// ==========================================================================
	always_comb begin
		lat_eff      = (lnk.cfg.latency_code == '0) ? PSBS_LC_MIN : lnk.cfg.latency_code;
		// bursts only start in synchronous mode; async accesses are unclocked
		start        = !ce_n_i && !adv_n_i && (lnk.cfg.operating_mode_bit == PSBS_MODE_SYNC);
		next_state   = state;
		next_cnt     = cnt;
		next_col     = col;
		next_left    = left;
		next_is_wr   = is_wr;
		next_cross_t = cross_t;
		next_start_t = start_t;
		early        = 1'b0;
		if (ce_n_i) begin
			// select high ends any burst at once
			next_state = PSBS_IDLE;
		end else begin
			case (state)
				PSBS_IDLE: begin
					if (start) begin
						next_state   = PSBS_LAT; // RL4
						next_cnt     = lat_eff - PSBS_LC_MIN; // RL5
						next_col     = col_i;
						next_left    = lnk.cfg.burst_words;
						next_is_wr   = !we_n_i;
						next_start_t = !start_t;
					end
				end
				PSBS_LAT: begin
					if (cnt == '0) begin
						next_state = PSBS_DATA;
					end else begin
						next_cnt = cnt - PSBS_LC_MIN;
					end
				end
				PSBS_DATA, PSBS_DONE: begin
					if (!adv_n_i && lnk.cfg.fixed_latency) begin
						// new access without select high, fixed latency only
						next_state   = PSBS_LAT; // RL10
						next_cnt     = lat_eff - PSBS_LC_MIN;
						next_col     = col_i;
						next_left    = lnk.cfg.burst_words;
						next_is_wr   = !we_n_i;
						next_start_t = !start_t;
					end else if (state == PSBS_DATA) begin
						next_col = col + 1'b1;
						if (left != PSBS_WORDS_CONT) begin
							next_left = left - 1'b1;
						end
						if (left == 6'h01) begin
							next_state = PSBS_DONE; // RL14
						end else if (col == ROW_LAST && !lnk.cfg.wrap) begin
							// next word lies in the next row
							next_state   = PSBS_LAT; // RL3
							next_cnt     = lat_eff - PSBS_LC_MIN;
							next_cross_t = !cross_t;
						end else begin
							early = (next_col == ROW_LAST) && !lnk.cfg.wrap && (left != 6'h02);
						end
					end
				end
				default: next_state = PSBS_IDLE;
			endcase
		end
		stall_act    = (next_state == PSBS_LAT) || (lnk.cfg.wait_timing_bit && early);
		next_wait    = (lnk.cfg.wait_polarity == PSBS_POL_LOW) ? !stall_act : stall_act; // RL15
		next_wait_oe = !ce_n_i; // RL15
		next_dq_oe   = !ce_n_i && !next_is_wr && (next_state == PSBS_DATA || next_state == PSBS_DONE);
		next_strobe  = (next_state == PSBS_DATA);
	end

	// ==========================================================================
	// registers; outputs describe the clock that follows the edge
	// ==========================================================================
	always_ff @(posedge clk_link_i or negedge rst_link_n) begin
		if (!rst_link_n) begin
			state         <= PSBS_IDLE;
			cnt           <= '0;
			col           <= '0;
			left          <= '0;
			is_wr         <= 1'b0;
			cross_t       <= 1'b0;
			start_t       <= 1'b0;
			wait_o        <= 1'b1;
			wait_oe_o     <= 1'b0;
			dq_oe_o       <= 1'b0;
			word_strobe_o <= 1'b0;
		end else begin
			state         <= next_state;
			cnt           <= next_cnt;
			col           <= next_col;
			left          <= next_left;
			is_wr         <= next_is_wr;
			cross_t       <= next_cross_t;
			start_t       <= next_start_t;
			wait_o        <= next_wait;
			wait_oe_o     <= next_wait_oe;
			dq_oe_o       <= next_dq_oe;
			word_strobe_o <= next_strobe;
		end
	end

	assign lnk.busy      = (state != PSBS_IDLE);
	assign lnk.cross_tgl = cross_t;
	assign lnk.start_tgl = start_t;

	// ==========================================================================
	// checks: stall run lengths measured by a helper counter, then burst start, burst end, floating and fixed restart
	// ==========================================================================
	logic [PSBS_LC_W:0] run; // consecutive stall clocks
	always_ff @(posedge clk_link_i or negedge rst_link_n) begin
		if (!rst_link_n) begin
			run <= '0;
		end else begin
			run <= (state == PSBS_LAT) ? run + 1'b1 : '0;
		end
	end

	AST_STALL_LEN: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // RL3
		(state == PSBS_LAT && next_state == PSBS_DATA && !ce_n_i) |-> (run + 1'b1 == {1'b0, lat_eff}))
		else $error("stall length differs from latency code");
	AST_START_STALL: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // RL4
		(state == PSBS_IDLE && start) |=> (state == PSBS_LAT))
		else $error("burst start did not stall");
	AST_LC2_FIRST: assert property (@(posedge clk_link_i) disable iff (!rst_link_n || ce_n_i) // RL5
		(state == PSBS_IDLE && start && lnk.cfg.latency_code == 3'h2) |=> state == PSBS_LAT ##1
		state == PSBS_LAT ##1 state == PSBS_DATA)
		else $error("latency code two did not give three clocks");
	AST_DONE_NO_WAIT: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // RL14
		(state == PSBS_DONE && !ce_n_i && adv_n_i) |=> (wait_o == (lnk.cfg.wait_polarity == PSBS_POL_LOW)))
		else $error("stall indicator asserted past burst end");
	AST_FLOAT_IDLE: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // RL15
		ce_n_i |=> !wait_oe_o && !dq_oe_o)
		else $error("indicator driven while deselected");
	AST_FIXED_RESTART: assert property (@(posedge clk_link_i) disable iff (!rst_link_n) // RL10
		(state == PSBS_DONE && !ce_n_i && !adv_n_i && lnk.cfg.fixed_latency) |=> state == PSBS_LAT)
		else $error("access after fixed burst not started on strobe");
endmodule : psbs_seq

// >>> core/psbs_top.sv
`timescale 1ns/1ps
// Operation
// (RL1) controller ends read at row end promptly
// (RL2) controller ends write at row end promptly
// (RL3) row crossing stalls latency-code clocks
// (RL4) burst start stalls latency-code clocks
// (RL5) latency code two gives three clocks
// (RL6) controller deselects after last defined word
// (RL7) controller grants refresh opportunity every window
// (RL8) deselect between async and variable bursts
// (RL9) async write to fixed read may continue
// (RL10) after fixed read, access starts on strobe
// (RL11) synchronous mode needs select high gap
// (RL12) otherwise gap only after select-ended writes
// (RL13) select and write strobe under four microseconds
// (RL14) past burst end indicator stays deasserted
// (RL15) indicator configured polarity, floats when deselected
// (RL16) controller tracks time since refresh opportunity
// ==========================================================================
// top: system-side configuration and status, link-side sequencer
// ==========================================================================
module psbs_top import psbs_pkg::*; #(
	parameter int COL_W = 7                          // column address width
) (
	input  wire logic                    clk_sys_i,            // system clock, 25 MHz
	input  wire logic                    resetn_i,             // async reset, active low
	input  wire logic                    clk_link_i,           // bus clock from controller
	input  wire logic                    ce_n_i,               // chip select, active low
	input  wire logic                    adv_n_i,              // address_valid_strobe, active low
	input  wire logic                    we_n_i,               // write strobe, active low
	input  wire logic [COL_W-1:0]        col_i,                // column address bits
	input  wire logic [PSBS_LC_W-1:0]    latency_code_field_i, // latency code
	input  wire logic                    wait_timing_bit_i,    // indicator one clock early
	input  wire logic                    operating_mode_bit_i, // 0: synchronous mode
	input  wire logic                    fixed_latency_i,      // fixed latency select
	input  wire logic                    wait_polarity_i,      // 0: indicator active low
	input  wire logic                    wrap_i,               // burst wrap enable
	input  wire logic [PSBS_WORDS_W-1:0] burst_words_i,        // burst length, 0 continuous
	output logic                         wait_o,               // stall indicator level
	output logic                         wait_oe_o,            // stall indicator enable
	output logic                         dq_oe_o,              // read data enable
	output logic                         word_strobe_o,        // data word this clock
	output logic                         busy_o,               // burst in progress, synced
	output logic [PSBS_CNT_W-1:0]        burst_cnt_o,          // bursts started
	output logic [PSBS_CNT_W-1:0]        cross_cnt_o           // row crossings seen
);
	psbs_link_if lnk ();

	// ==========================================================================
	// system side: configuration register
	// ==========================================================================
	psbs_cfg_s cfg_sys, next_cfg_sys; // bus_config_reg image in the system domain

	always_comb begin
		next_cfg_sys = '{latency_code_field_i, wait_timing_bit_i, operating_mode_bit_i,
			fixed_latency_i, wait_polarity_i, wrap_i, burst_words_i};
	end

	// config registered so the crossing sees clean flop outputs
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_sys <= PSBS_CFG_RST;
		end else begin
			cfg_sys <= next_cfg_sys;
		end
	end

	// ==========================================================================
	// link side: reset and configuration crossing
	// ==========================================================================
	logic      rst_l1, rst_l2;    // link reset synchroniser
	psbs_cfg_s cfg_l1, cfg_l2;    // config synchroniser stages

	// reset asserts at once and releases on the link clock; the bus clock may
	// stand still outside accesses, so release waits for the first two edges
	always_ff @(posedge clk_link_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_l1 <= 1'b0;
			rst_l2 <= 1'b0;
		end else begin
			rst_l1 <= 1'b1;
			rst_l2 <= rst_l1;
		end
	end

	// configuration is quasi-static: software changes it only with select high,
	// so a plain two-stage level crossing is enough and no handshake is spent
	always_ff @(posedge clk_link_i or negedge rst_l2) begin
		if (!rst_l2) begin
			cfg_l1 <= PSBS_CFG_RST;
			cfg_l2 <= PSBS_CFG_RST;
		end else begin
			cfg_l1 <= cfg_sys;
			cfg_l2 <= cfg_l1;
		end
	end

	assign lnk.cfg = cfg_l2;

	// ==========================================================================
	// sequencer instance
	// ==========================================================================
	psbs_seq #(
		.COL_W (COL_W)
	) u_seq (
		.clk_link_i    (clk_link_i),
		.rst_link_n    (rst_l2),
		.ce_n_i        (ce_n_i),
		.adv_n_i       (adv_n_i),
		.we_n_i        (we_n_i),
		.col_i         (col_i),
		.lnk           (lnk.seq),
		.wait_o        (wait_o),
		.wait_oe_o     (wait_oe_o),
		.dq_oe_o       (dq_oe_o),
		.word_strobe_o (word_strobe_o)
	);

	// ==========================================================================
	// status crossing back to the system clock
	// ==========================================================================
	logic busy_s1;                     // first stage, read only by busy_o
	logic cross_s1, cross_s2, cross_s3; // crossing toggle stages
	logic start_s1, start_s2, start_s3; // start toggle stages

	// events travel as toggles, so none is lost however slow the bus clock runs
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_s1  <= 1'b0;
			busy_o   <= 1'b0;
			cross_s1 <= 1'b0;
			cross_s2 <= 1'b0;
			cross_s3 <= 1'b0;
			start_s1 <= 1'b0;
			start_s2 <= 1'b0;
			start_s3 <= 1'b0;
		end else begin
			busy_s1  <= lnk.busy;
			busy_o   <= busy_s1;
			cross_s1 <= lnk.cross_tgl;
			cross_s2 <= cross_s1;
			cross_s3 <= cross_s2;
			start_s1 <= lnk.start_tgl;
			start_s2 <= start_s1;
			start_s3 <= start_s2;
		end
	end

	// ==========================================================================
	// status counters
	// ==========================================================================
	logic                  cross_ev, start_ev;                 // one-clock events
	logic [PSBS_CNT_W-1:0] next_cross_cnt, next_burst_cnt;    // counter next values

	always_comb begin
		cross_ev       = cross_s2 ^ cross_s3;
		start_ev       = start_s2 ^ start_s3;
		// counters wrap silently; software reads differences
		next_cross_cnt = cross_ev ? cross_cnt_o + 1'b1 : cross_cnt_o; // RL3
		next_burst_cnt = start_ev ? burst_cnt_o + 1'b1 : burst_cnt_o; // RL4
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cross_cnt_o <= '0;
			burst_cnt_o <= '0;
		end else begin
			cross_cnt_o <= next_cross_cnt;
			burst_cnt_o <= next_burst_cnt;
		end
	end

	// ==========================================================================
	// checks on the system side
	// ==========================================================================
	AST_CROSS_COUNT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RL3
		cross_ev |=> cross_cnt_o == $past(cross_cnt_o) + 1'b1)
		else $error("row crossing not counted");
	AST_START_COUNT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RL4
		(!start_ev ##1 !start_ev) |-> $stable(burst_cnt_o))
		else $error("burst counter moved without a start");
endmodule : psbs_top

// >>> verif/psbs_ctl_model.sv
`timescale 1ns/1ps
// ==========================================================================
// controller model: makes the bus clock inside frames and in deselected idle clocks
// ==========================================================================
module psbs_ctl_model (
	input  wire logic       wait_i,     // stall indicator level
	input  wire logic       wait_oe_i,  // stall indicator driven
	input  wire logic       dq_oe_i,    // read data driven
	input  wire logic       strobe_i,   // a data word moved
	output logic            clk_link_o, // bus clock, stands high between frames
	output logic            ce_n_o,     // chip select, active low
	output logic            adv_n_o,    // address_valid_strobe, active low
	output logic            we_n_o,     // write strobe, active low
	output logic [6:0]      col_o       // start column
);
	initial begin
		clk_link_o = 1'b0;
		ce_n_o     = 1'b1;
		adv_n_o    = 1'b1;
		we_n_o     = 1'b1;
		col_o      = 7'h55;
	end

	// one bus clock; returns just after the rising edge so outputs have settled
	task automatic tick();
		#23 clk_link_o = 1'b0;
		#24 clk_link_o = 1'b1;
		#1;
	endtask : tick

	// deselected clocks: each one is a clocked refresh opportunity
	task automatic idle(input int n);
		ce_n_o = 1'b1;
		repeat (n) tick();
	endtask : idle

	// one burst; the count of selected clocks stays far below four microseconds
	task automatic burst(input logic wr, input logic [6:0] col, input int ncyc, input logic pol,
		input logic end_row, output int lat, output int words, output int drv, output logic quiet);
		lat   = 0;
		words = 0;
		drv   = 0;
		ce_n_o  = 1'b0;
		adv_n_o = 1'b0;
		we_n_o  = ~wr;
		col_o   = col;
		for (int i = 0; i < ncyc; i++) begin
			tick();
			adv_n_o = 1'b1;
			we_n_o  = 1'b1;
			col_o   = ~col; // address hold is over, the bus no longer shows it
			if (strobe_i === 1'b1) words++;
			if (dq_oe_i === 1'b1) drv++;
			if (wait_oe_i === 1'b1 && wait_i === pol) begin
				lat++;
				// stall at the row end: deselect before the next clock
				if (end_row && words > 0) break;
			end
		end
		ce_n_o = 1'b1;
		tick();
		quiet = (wait_oe_i === 1'b0) && (dq_oe_i === 1'b0);
	endtask : burst
endmodule : psbs_ctl_model

// >>> verif/test_psbs_burst_bus_sequencing.sv
`timescale 1ns/1ps
// ==========================================================================
// bench: random and corner bursts against the sequencer
// ==========================================================================
module test_psram_burst_bus_sequencing;
	import psbs_pkg::*;
	localparam int LIMIT = 20000;        // sys cycles; the run needs about a thirtieth
	logic          clk_sys_i;            // system clock
	logic          resetn_i;             // async reset, active low
	logic          clk_link;             // bus clock from the model
	logic          ce_n, adv_n, we_n;    // bus controls from the model
	logic [6:0]    col;                  // start column
	logic [2:0]    lc;                   // latency code
	logic          wtb, omb, fixl, pol;  // configuration bits
	logic          wrap;                 // wrap, kept off for row tests
	logic [5:0]    bw;                   // burst length
	logic          wait_l, wait_oe;      // stall indicator
	logic          dq_oe, strobe, busy;  // data and status
	logic [7:0]    bcnt, xcnt;           // status counters
	int            error_cnt, checked;   // verdict counters
	int            cyc, nb, seed;        // timeout, expected bursts, seed
	int            lat, words, drv;      // measured by the model
	logic          quiet;                // indicator and data floated
	logic [31:0]   r;                    // random draw

	psbs_top #(.COL_W(7)) DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .clk_link_i(clk_link),
		.ce_n_i(ce_n), .adv_n_i(adv_n), .we_n_i(we_n), .col_i(col), .latency_code_field_i(lc),
		.wait_timing_bit_i(wtb), .operating_mode_bit_i(omb), .fixed_latency_i(fixl),
		.wait_polarity_i(pol), .wrap_i(wrap), .burst_words_i(bw), .wait_o(wait_l),
		.wait_oe_o(wait_oe), .dq_oe_o(dq_oe), .word_strobe_o(strobe), .busy_o(busy),
		.burst_cnt_o(bcnt), .cross_cnt_o(xcnt));

	psbs_ctl_model ctl (.wait_i(wait_l), .wait_oe_i(wait_oe), .dq_oe_i(dq_oe), .strobe_i(strobe),
		.clk_link_o(clk_link), .ce_n_o(ce_n), .adv_n_o(adv_n), .we_n_o(we_n), .col_o(col));

	// ==========================================================================
	// clock, timeout and verdict
	// ==========================================================================
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	// a hang counts as a mismatch and goes to the verdict
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			results();
		end
	end

	task automatic results();
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// stall length expected for a code; zero still stalls one clock
	function automatic int exp_lat(input logic [2:0] code);
		return (code == 3'h0) ? 1 : int'(code);
	endfunction : exp_lat

	// ==========================================================================
	// configuration and one checked burst
	// ==========================================================================
	task automatic setcfg(input logic [2:0] l, input logic t, input logic m, input logic [5:0] b,
		input logic p, input logic f);
		@(posedge clk_sys_i);
		lc   <= l;
		wtb  <= t;
		omb  <= m;
		bw   <= b;
		pol  <= p;
		fixl <= f;
		repeat (3) @(posedge clk_sys_i);
		ctl.idle(4); // carries the settings into the link domain
	endtask : setcfg

	task automatic run(input logic wr, input logic [6:0] c, input int n, input logic er,
		input int el, input int ew);
		ctl.burst(wr, c, n, pol, er, lat, words, drv, quiet);
		if (omb == PSBS_MODE_SYNC) nb++;
		repeat (10) @(posedge clk_sys_i);
		check("stall_clocks", lat, el);
		check("data_words", words, ew);
		check("read_drive", drv > 0, !wr && ew > 0);
		check("floated", quiet, 1'b1);
		check("burst_count", bcnt, nb);
		check("busy_idle", busy, 1'b0);
	endtask : run

	// ==========================================================================
	// main sequence
	// ==========================================================================
	initial begin
		resetn_i = 1'b0;
		lc = PSBS_LC_RST;
		wtb = 1'b0;
		omb = PSBS_MODE_SYNC;
		fixl = 1'b0;
		pol = PSBS_POL_LOW;
		wrap = 1'b0;
		bw = PSBS_WORDS_RST;
		error_cnt = 0;
		checked = 0;
		cyc = 0;
		nb = 0;
		seed = 32;
		fork
			repeat (16) @(posedge clk_sys_i);
			begin
				#7 ctl.idle(4);
			end
		join
		check("reset_wait", wait_l, 1'b1);
		check("reset_float", wait_oe, 1'b0);
		check("reset_count", bcnt, 8'h00);
		@(posedge clk_sys_i);
		resetn_i <= 1'b1;
		#5 ctl.idle(6);
		// reset settings: code two, four words, read then write
		run(1'b0, 7'h05, 8, 1'b0, 2, 4);
		run(1'b1, 7'h05, 8, 1'b0, 2, 4);
		// continuous bursts across the row end stall again
		setcfg(3'h3, 1'b0, PSBS_MODE_SYNC, 6'h00, PSBS_POL_LOW, 1'b0);
		run(1'b0, 7'h7e, 11, 1'b0, 6, 5);
		run(1'b1, 7'h7e, 11, 1'b0, 6, 5);
		check("row_crossings", xcnt, 8'h02);
		// end of row with wrap off, both wait timings, read and write
		for (int k = 0; k < 4; k++) begin
			setcfg(3'h2, k[0], PSBS_MODE_SYNC, 6'h00, PSBS_POL_LOW, k[1]);
			run(k[1], 7'h7e, 20, 1'b1, 3, 2);
		end
		// a code of zero still stalls one clock
		setcfg(3'h0, 1'b0, PSBS_MODE_SYNC, 6'h02, PSBS_POL_LOW, 1'b0);
		run(1'b0, 7'h20, 5, 1'b0, 1, 2);
		// random codes, lengths, polarities and latency modes
		for (int k = 0; k < 12; k++) begin
			r = $random(seed);
			setcfg(r[2:0], 1'b0, PSBS_MODE_SYNC, {3'h0, r[5:3]} + 6'h01, r[6], r[7]);
			run(r[8], 7'(r[15:9] % 100), exp_lat(r[2:0]) + int'(r[5:3]) + 3, 1'b0,
				exp_lat(r[2:0]), int'(r[5:3]) + 1);
		end
		// asynchronous mode: no burst starts
		setcfg(3'h2, 1'b0, ~PSBS_MODE_SYNC, 6'h04, PSBS_POL_LOW, 1'b0);
		run(1'b0, 7'h10, 6, 1'b0, 0, 0);
		results();
	end
endmodule : test_psram_burst_bus_sequencing
